/* hdl/rs485_gate_pkg.sv */
/*
  shared constants and state types for the rs-422/485 transmit-gate block.
  assumes a 250 MHz system clock; bit rate set by a cycles-per-bit divisor.
*/
`default_nettype none

package rs485_gate_pkg;

  // clock and gate-off timing
  localparam int CLK_PERIOD_NS     = 4;
  localparam int SLOW_GATE_OFF_NS  = 3_000_000;  // low-rate gate-off hold
  localparam int SLOW_GATE_OFF_CYC = SLOW_GATE_OFF_NS / CLK_PERIOD_NS;

  // character layout
  localparam int DATA_BITS      = 8;
  localparam int PREAMBLE_CHARS = 2;
  localparam logic [3:0] FRAME_BITS_NOPAR = 4'hA;   // start, 8 data, stop
  localparam logic [3:0] FRAME_BITS_PAR   = 4'hB;   // plus even parity
  localparam logic [2:0] LAST_DATA_IDX    = 3'h7;
  localparam logic [3:0] LAST_RX_IDX_NOPAR = 4'h7;
  localparam logic [3:0] LAST_RX_IDX_PAR   = 4'h8;
  localparam logic       MARK  = 1'b1;
  localparam logic       SPACE = 1'b0;

  // transmit states, one-hot
  typedef enum logic [6:0] {
    TX_IDLE     = 7'h01,
    TX_PREAMBLE = 7'h02,
    TX_START    = 7'h04,
    TX_DATA     = 7'h08,
    TX_PARITY   = 7'h10,
    TX_STOP     = 7'h20,
    TX_HOLD     = 7'h40
  } tx_state_e;

  // receive states, one-hot
  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_SHIFT = 4'h4,
    RX_STOP  = 4'h8
  } rx_state_e;

endpackage : rs485_gate_pkg

`default_nettype wire

/* hdl/rx_char_if.sv */
/*
  carries one received character from the receiver to the top module.
  assumes both ends share the system clock.
*/
`timescale 1ns/1ns
`default_nettype none

interface rx_char_if;
  logic [7:0] data;
  logic       valid;      // one-cycle pulse per character
  logic       parity_err;
  logic       framing_err;

  modport src (output data, output valid, output parity_err, output framing_err);
  modport snk (input data, input valid, input parity_err, input framing_err);
endinterface : rx_char_if

`default_nettype wire

/* hdl/rx_char_receiver.sv */
/*
  character receiver: samples the synchronised receive pair level mid-bit,
  checks even parity and the stop bit. assumes rx_bit_i is already
  synchronised to sys_clk_i and the divisor is at least two.
*/
`timescale 1ns/1ns
`default_nettype none

module rx_char_receiver
  import rs485_gate_pkg::*;
#(
  parameter int DIV_W = 16
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_b_i,
  // configuration
  input  wire logic [DIV_W-1:0] bit_div_i,
  input  wire logic             parity_en_i,
  // line level and character out
  input  wire logic             rx_bit_i,
  rx_char_if.src                rx
);

  rx_state_e        state_r, state_nxt;
  logic [DIV_W-1:0] cnt_r, cnt_nxt;
  logic [3:0]       idx_r, idx_nxt;
  logic [7:0]       sh_r, sh_nxt;
  logic             par_r, par_nxt;
  logic             valid_r, valid_nxt;
  logic             perr_r, perr_nxt;
  logic             ferr_r, ferr_nxt;
  logic             bit_end;

  assign bit_end = (cnt_r == bit_div_i - 1'b1);

  // next-state for framing, sampling at the centre of each bit
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = bit_end ? '0 : cnt_r + 1'b1;
    idx_nxt   = idx_r;
    sh_nxt    = sh_r;
    par_nxt   = par_r;
    valid_nxt = 1'b0;
    perr_nxt  = perr_r;
    ferr_nxt  = ferr_r;
    case (state_r)
      RX_IDLE: begin
        cnt_nxt = '0;
        if (rx_bit_i == SPACE) begin
          state_nxt = RX_START;
        end
      end
      RX_START: begin
        if (cnt_r == (bit_div_i >> 1)) begin
          cnt_nxt   = '0;
          idx_nxt   = '0;
          state_nxt = (rx_bit_i == SPACE) ? RX_SHIFT : RX_IDLE;  // reject glitch
        end
      end
      RX_SHIFT: begin
        if (bit_end) begin
          if (idx_r == LAST_RX_IDX_PAR) begin
            par_nxt = rx_bit_i;
          end else begin
            sh_nxt = {rx_bit_i, sh_r[7:1]};
          end
          idx_nxt = idx_r + 1'b1;
          if (idx_r == (parity_en_i ? LAST_RX_IDX_PAR : LAST_RX_IDX_NOPAR)) begin
            state_nxt = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (bit_end) begin
          valid_nxt = 1'b1;
          perr_nxt  = parity_en_i & ((^sh_r) ^ par_r);   // even-parity error, flagged to the top module
          ferr_nxt  = (rx_bit_i != MARK);
          state_nxt = RX_IDLE;
        end
      end
      default: state_nxt = RX_IDLE;
    endcase
  end

  // state registers
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= RX_IDLE;
      cnt_r   <= '0;
      idx_r   <= '0;
      sh_r    <= 8'h00;
      par_r   <= 1'b0;
      valid_r <= 1'b0;
      perr_r  <= 1'b0;
      ferr_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      idx_r   <= idx_nxt;
      sh_r    <= sh_nxt;
      par_r   <= par_nxt;
      valid_r <= valid_nxt;
      perr_r  <= perr_nxt;
      ferr_r  <= ferr_nxt;
    end
  end

  assign rx.data        = sh_r;
  assign rx.valid       = valid_r;
  assign rx.parity_err  = perr_r;
  assign rx.framing_err = ferr_r;

endmodule : rx_char_receiver

`default_nettype wire

/* hdl/rs485_driver_gate_control.sv */
/*
  rs-422/485 port with automatic transmit-gate control: serialises
  characters onto the transmit pair, drives the line driver enable, sends
  a mark preamble and releases the driver after the last character.
  assumes configuration inputs come from logic on sys_clk_i; the receive
  pair comes from pins and is synchronised here.
*/
`timescale 1ns/1ns
`default_nettype none

module rs485_driver_gate_control
  import rs485_gate_pkg::*;
#(
  parameter int DIV_W        = 16,
  parameter int SLOW_OFF_CYC = SLOW_GATE_OFF_CYC
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_b_i,
  // configuration
  input  wire logic [DIV_W-1:0] bit_div_i,
  input  wire logic             parity_en_i,
  input  wire logic             slow_rate_i,
  input  wire logic             linked_mode_i,
  // transmit character stream
  input  wire logic [7:0]       tx_data_i,
  input  wire logic             tx_valid_i,
  output logic                  tx_ready_o,
  // line pins
  output logic                  tx_pair_pos_o,
  output logic                  tx_pair_neg_o,
  output logic                  tx_pair_oe_o,
  input  wire logic             rx_pair_pos_i,
  input  wire logic             rx_pair_neg_i,
  // received characters
  output logic [7:0]            rx_data_o,
  output logic                  rx_valid_o,
  output logic                  rx_parity_err_o,
  output logic                  rx_framing_err_o
);

  localparam int HOLD_W = $clog2(SLOW_OFF_CYC + 1);
  localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(SLOW_OFF_CYC - 1);

  // elaboration checks
  if (DIV_W < 2) begin : g_bad_div
    $error("DIV_W must be at least 2");
  end
  if (SLOW_OFF_CYC < 1) begin : g_bad_hold
    $error("SLOW_OFF_CYC must be at least 1");
  end

  // reset release through two flip-flops
  logic [1:0] rst_sync_r;
  logic       rst_n;
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // two-stage synchronisers for the receive pair
  logic [1:0] rx_meta_r;
  logic [1:0] rx_sync_r;
  logic       rx_bit;
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_meta_r <= {SPACE, MARK};
      rx_sync_r <= {SPACE, MARK};
    end else begin
      rx_meta_r <= {rx_pair_neg_i, rx_pair_pos_i};
      rx_sync_r <= rx_meta_r;
    end
  end
  // undriven or equal pair reads as mark
  assign rx_bit = (rx_sync_r[0] != rx_sync_r[1]) ? rx_sync_r[0] : MARK;

  // receiver
  rx_char_if rx_if ();
  rx_char_receiver #(
    .DIV_W (DIV_W)
  ) u_rx (
    .sys_clk_i   (sys_clk_i),
    .rst_b_i     (rst_n),
    .bit_div_i   (bit_div_i),
    .parity_en_i (parity_en_i),
    .rx_bit_i    (rx_bit),
    .rx          (rx_if.src)
  );

  // registered receive outputs
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_data_o        <= 8'h00;
      rx_valid_o       <= 1'b0;
      rx_parity_err_o  <= 1'b0;
      rx_framing_err_o <= 1'b0;
    end else begin
      rx_data_o        <= rx_if.data;
      rx_valid_o       <= rx_if.valid;
      rx_parity_err_o  <= rx_if.parity_err;
      rx_framing_err_o <= rx_if.framing_err;
    end
  end

  // transmit state
  tx_state_e         state_r, state_nxt;
  logic [DIV_W-1:0]  div_r, div_nxt;
  logic [4:0]        idx_r, idx_nxt;
  logic [7:0]        sh_r, sh_nxt;
  logic              par_r, par_nxt;
  logic [HOLD_W-1:0] hold_r, hold_nxt;
  logic              line_nxt;
  logic              ready_nxt;
  logic              oe_nxt;
  logic              neg_nxt;
  logic              accept;
  logic              tick;
  logic [3:0]        frame_bits;
  logic [4:0]        preamble_last;

  assign accept        = tx_valid_i & tx_ready_o;
  assign tick          = (div_r == bit_div_i - 1'b1);
  assign frame_bits    = parity_en_i ? FRAME_BITS_PAR : FRAME_BITS_NOPAR;
  assign preamble_last = 5'(PREAMBLE_CHARS * frame_bits - 1);

  // next-state for the transmitter and gate
  always_comb begin
    state_nxt = state_r;
    div_nxt   = tick ? '0 : div_r + 1'b1;
    idx_nxt   = idx_r;
    sh_nxt    = sh_r;
    par_nxt   = par_r;
    hold_nxt  = hold_r;
    if (accept) begin
      sh_nxt  = tx_data_i;
      par_nxt = ^tx_data_i;
      div_nxt = '0;
      idx_nxt = '0;
    end
    case (state_r)
      TX_IDLE: begin
        div_nxt = '0;
        if (accept) begin
          state_nxt = TX_PREAMBLE;   // gate on, line at mark
        end
      end
      TX_PREAMBLE: begin
        if (tick) begin
          idx_nxt = idx_r + 1'b1;
          if (idx_r == preamble_last) begin
            idx_nxt   = '0;
            state_nxt = TX_START;
          end
        end
      end
      TX_START: begin
        if (tick) begin
          state_nxt = TX_DATA;
        end
      end
      TX_DATA: begin
        if (tick) begin
          sh_nxt  = {1'b0, sh_r[7:1]};
          idx_nxt = idx_r + 1'b1;
          if (idx_r[2:0] == LAST_DATA_IDX) begin
            idx_nxt   = '0;
            state_nxt = parity_en_i ? TX_PARITY : TX_STOP;
          end
        end
      end
      TX_PARITY: begin
        if (tick) begin
          state_nxt = TX_STOP;
        end
      end
      TX_STOP: begin
        if (tick) begin
          hold_nxt  = '0;   // delay counts only from here
          idx_nxt   = '0;
          state_nxt = TX_HOLD;
        end
      end
      TX_HOLD: begin
        hold_nxt = hold_r + 1'b1;
        if (accept) begin
          state_nxt = TX_START;   // next character, gate kept on
        end else if (linked_mode_i) begin
          if (tick) begin
            idx_nxt = idx_r + 1'b1;
            if (idx_r == 5'(frame_bits - 1'b1)) begin
              state_nxt = TX_IDLE;   // one character time
            end
          end
        end else if (slow_rate_i) begin
          if (hold_r == HOLD_LAST) begin
            state_nxt = TX_IDLE;
          end
        end else begin
          state_nxt = TX_IDLE;   // one cycle, well within a bit
        end
      end
      default: state_nxt = TX_IDLE;
    endcase

    // line level for the next state
    case (state_nxt)
      TX_START:  line_nxt = SPACE;
      TX_DATA:   line_nxt = sh_nxt[0];
      TX_PARITY: line_nxt = par_nxt;
      default:   line_nxt = MARK;
    endcase
    ready_nxt = (state_nxt == TX_IDLE) || ((state_nxt == TX_HOLD) && !accept);
    neg_nxt   = ~line_nxt;
    oe_nxt    = (state_nxt != TX_IDLE);
  end

  // transmit registers and pins
  always_ff @(posedge sys_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_r       <= TX_IDLE;
      div_r         <= '0;
      idx_r         <= '0;
      sh_r          <= 8'h00;
      par_r         <= 1'b0;
      hold_r        <= '0;
      tx_ready_o    <= 1'b0;
      tx_pair_pos_o <= MARK;
      tx_pair_neg_o <= ~MARK;
      tx_pair_oe_o  <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      div_r         <= div_nxt;
      idx_r         <= idx_nxt;
      sh_r          <= sh_nxt;
      par_r         <= par_nxt;
      hold_r        <= hold_nxt;
      tx_ready_o    <= ready_nxt;
      tx_pair_pos_o <= line_nxt;
      tx_pair_neg_o <= neg_nxt;
      tx_pair_oe_o  <= oe_nxt;
    end
  end

endmodule : rs485_driver_gate_control

`default_nettype wire

/* verif/rs485_gate_asserts.sv */
/* port assertions for the transmit gate block.
   bound into every instance of the block; one clock domain. */
`timescale 1ns/1ns
`default_nettype none
module rs485_gate_asserts #(
  parameter int DIV_W        = 16,
  parameter int SLOW_OFF_CYC = 20
) (
  // clock, reset, configuration
  input wire logic             sys_clk_i,
  input wire logic             rst_b_i,
  input wire logic [DIV_W-1:0] bit_div_i,
  input wire logic             parity_en_i,
  input wire logic             slow_rate_i,
  input wire logic             linked_mode_i,
  // watched traffic
  input wire logic             tx_valid_i,
  input wire logic             tx_ready_o,
  input wire logic             tx_pair_pos_o,
  input wire logic             tx_pair_neg_o,
  input wire logic             tx_pair_oe_o,
  input wire logic             rx_valid_o
);
  int   fb, lim, hold_cnt, mark_cnt;
  logic pre_r, take_r;
  // frame length and expected gate-off hold
  assign fb  = parity_en_i ? 11 : 10;
  assign lim = linked_mode_i ? fb * int'(bit_div_i) : (slow_rate_i ? SLOW_OFF_CYC : 1);
  // hold length, mark run and preamble trackers
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_cnt <= 0;
      mark_cnt <= 0;
      pre_r    <= 1'b1;
      take_r   <= 1'b0;
    end else begin
      hold_cnt <= (tx_pair_oe_o && tx_ready_o) ? hold_cnt + 1 : 0;
      mark_cnt <= (tx_pair_oe_o && tx_pair_pos_o) ? mark_cnt + 1 : 0;
      pre_r    <= !tx_pair_oe_o || (pre_r && tx_pair_pos_o);
      take_r   <= tx_valid_i && tx_ready_o;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);
  // acceptance steps
  sequence s_take; tx_valid_i && tx_ready_o; endsequence
  sequence s_take_idle; s_take ##0 !tx_pair_oe_o; endsequence
  property p_pair_inv; tx_pair_neg_o == !tx_pair_pos_o; endproperty
  property p_idle_mark; !tx_pair_oe_o |-> tx_pair_pos_o; endproperty
  property p_gate_on; s_take_idle |=> tx_pair_oe_o && tx_pair_pos_o && !tx_ready_o; endproperty
  property p_gate_cause; $rose(tx_pair_oe_o) |-> take_r; endproperty
  property p_take_drop; s_take |=> !tx_ready_o; endproperty
  property p_preamble;
    pre_r && tx_pair_oe_o && !tx_pair_pos_o |-> mark_cnt >= 2 * fb * int'(bit_div_i);
  endproperty
  property p_stop_whole; $rose(tx_ready_o) && tx_pair_oe_o |-> mark_cnt + 1 >= int'(bit_div_i); endproperty
  property p_off_late; tx_pair_oe_o && tx_ready_o |-> hold_cnt <= lim + 2; endproperty
  property p_off_early; $fell(tx_pair_oe_o) |-> hold_cnt + 2 >= lim; endproperty
  property p_rx_pulse; rx_valid_o |=> !rx_valid_o; endproperty
  a_pair_inv: assert property (p_pair_inv) else $error("pair not complementary");
  a_idle_mark: assert property (p_idle_mark) else $error("idle line not mark");
  a_gate_on: assert property (p_gate_on) else $error("gate late after accept");
  a_gate_cause: assert property (p_gate_cause) else $error("gate without send");
  a_take_drop: assert property (p_take_drop) else $error("ready kept after accept");
  a_preamble: assert property (p_preamble) else $error("mark preamble short");
  a_stop_whole: assert property (p_stop_whole) else $error("stop bit cut");
  a_off_late: assert property (p_off_late) else $error("gate held too long");
  a_off_early: assert property (p_off_early) else $error("gate dropped early");
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx valid not a pulse");
endmodule : rs485_gate_asserts

bind rs485_driver_gate_control rs485_gate_asserts #(.DIV_W(DIV_W), .SLOW_OFF_CYC(SLOW_OFF_CYC))
  chk_u (.sys_clk_i, .rst_b_i, .bit_div_i, .parity_en_i, .slow_rate_i, .linked_mode_i,
         .tx_valid_i, .tx_ready_o, .tx_pair_pos_o, .tx_pair_neg_o, .tx_pair_oe_o, .rx_valid_o);
`default_nettype wire

/* verif/serial_peer_model.sv */
/* far-end serial device: listens on the transmit pair, drives the
   receive pair. assumes a pull-up holds a released pair at mark. */
`timescale 1ns/1ns
`default_nettype none
module serial_peer_model #(
  parameter logic [7:0] LEAD = 8'h3A  // leading character of a message
) (
  // line and settings
  input  wire logic        clk_i,
  input  wire logic [15:0] div_i,
  input  wire logic        par_i,
  input  wire logic        pos_i,
  input  wire logic        oe_i,
  output logic             rx_pos_o,
  output logic             rx_neg_o
);
  logic [7:0] got[$];
  logic [9:0] b;
  logic       line;
  logic       seen = 1'b0;
  int         nb;
  assign line = oe_i ? pos_i : 1'b1;  // released pair floats to mark
  initial rx_pos_o = 1'b1;
  initial rx_neg_o = 1'b0;
  // receive, drop errored and pre-lead characters
  initial forever begin
    @(posedge clk_i iff line === 1'b0);
    nb = par_i ? 10 : 9;
    repeat (div_i / 2) @(posedge clk_i);
    for (int i = 0; i < nb; i++) begin
      repeat (div_i) @(posedge clk_i);
      b[i] = line;
    end
    if (b[nb-1] && !(par_i && ^b[8:0])) begin
      seen = seen || b[7:0] == LEAD;
      if (seen) got.push_back(b[7:0]);
    end
  end
  // send one character, optionally corrupted
  task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    logic [10:0] f;
    f = par_i ? {~bad_stop, ^d ^ bad_par, d, 1'b0} : {2'b11 ^ {1'b0, bad_stop}, d, 1'b0};
    for (int i = 0; i < (par_i ? 11 : 10); i++) begin
      rx_pos_o <= f[i];
      rx_neg_o <= ~f[i];
      repeat (div_i) @(posedge clk_i);
    end
    rx_pos_o <= 1'b1;
    rx_neg_o <= 1'b0;
    repeat (2 * div_i) @(posedge clk_i);
  endtask : send
endmodule : serial_peer_model
`default_nettype wire

/* verif/rs485_driver_gate_control_tb_top.sv */
/* testbench: random and corner characters both ways through the gate
   block with a far-end model. assumes a 20-cycle slow gate-off. */
`timescale 1ns/1ns
`default_nettype none
module rs485_driver_gate_control_tb_top;
  import rs485_gate_pkg::*;
  localparam logic [7:0] LEAD = 8'h3A;
  logic        clk, rst_b, par, slow, linked, tx_valid, rx_pos, rx_neg;
  logic        tx_ready, tx_pos, tx_neg, tx_oe, rx_valid, rx_perr, rx_ferr;
  logic [15:0] div;
  logic [7:0]  tx_data, rx_data, d;
  logic [7:0]  exp_q[$];
  logic [9:0]  rx_q[$], exp_rx[$];
  int          num_errors, checked, n;
  rs485_driver_gate_control #(.SLOW_OFF_CYC(20)) dut_u (
    .sys_clk_i(clk), .rst_b_i(rst_b), .bit_div_i(div), .parity_en_i(par),
    .slow_rate_i(slow), .linked_mode_i(linked), .tx_data_i(tx_data),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .tx_pair_pos_o(tx_pos),
    .tx_pair_neg_o(tx_neg), .tx_pair_oe_o(tx_oe), .rx_pair_pos_i(rx_pos),
    .rx_pair_neg_i(rx_neg), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
    .rx_parity_err_o(rx_perr), .rx_framing_err_o(rx_ferr));
  serial_peer_model #(.LEAD(LEAD)) peer_u (
    .clk_i(clk), .div_i(div), .par_i(par), .pos_i(tx_pos), .oe_i(tx_oe),
    .rx_pos_o(rx_pos), .rx_neg_o(rx_neg));
  // clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // collect received characters with their flags
  always @(posedge clk) if (rx_valid === 1'b1) rx_q.push_back({rx_ferr, rx_perr, rx_data});
  function automatic logic [9:0] rx_word(logic [7:0] v, logic bp, logic bs);
    return {bs, bp, v};
  endfunction : rx_word
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      num_errors++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask : check
  task automatic conclude;
    $display("checked %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  // hold a request until taken; valid stays up for back-to-back
  task automatic put(input logic [7:0] v);
    tx_data  <= v;
    tx_valid <= 1'b1;
    n = 0;
    do @(posedge clk); while (tx_ready !== 1'b1 && ++n < 5000);
    if (n >= 5000) num_errors++;  // request never taken
  endtask : put
  task automatic go_idle;
    tx_valid <= 1'b0;
    n = 0;
    do @(posedge clk); while ((tx_oe !== 1'b0 || tx_ready !== 1'b1) && ++n < 5000);
    if (n >= 5000) num_errors++;  // gate never released
  endtask : go_idle
  // watchdog, far beyond the few thousand cycles the tests need
  initial begin
    #200000;
    num_errors++;
    conclude();
  end
  initial begin
    void'($urandom(32'h49970E06));
    {rst_b, slow, linked, tx_valid, par} = 5'h00;
    tx_data = 8'h00;
    div = 16'h0004;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    // fast, slow and linked gate-off, random rate; parity off, on, then random
    for (int m = 0; m < 3; m++) begin
      slow   <= (m == 1);
      linked <= (m == 2);
      par    <= (m == 2) ? 1'($urandom_range(1)) : m[0];
      div    <= 16'(4 + $urandom_range(3));
      @(posedge clk);
      if (m == 0) put(8'h55);  // far end drops this
      if (m == 0) put(LEAD);
      if (m == 0) exp_q.push_back(LEAD);
      for (int k = 0; k < 3; k++) begin
        d = 8'($urandom);
        exp_q.push_back(d);
        put(d);
      end
      go_idle();
    end
    check(peer_u.got.size(), exp_q.size());
    foreach (exp_q[i]) check(peer_u.got[i], exp_q[i]);
    // received characters: good, bad parity, bad stop; parity then none
    for (int k = 0; k < 6; k++) begin
      par <= (k < 3);
      @(posedge clk);
      d = 8'($urandom);
      exp_rx.push_back(rx_word(d, k == 2, k == 4));
      peer_u.send(d, k == 2, k == 4);
    end
    repeat (20) @(posedge clk);
    check(rx_q.size(), exp_rx.size());
    foreach (exp_rx[i]) check(rx_q[i], exp_rx[i]);
    conclude();
  end
endmodule : rs485_driver_gate_control_tb_top
`default_nettype wire
